// file: pwr_regs.v
// Watchdog service register and temperature / low-voltage monitor registers on APB
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "pwr_defs.vh"

module pwr_regs #(
	parameter ADDR_W = 12,
	parameter RATE_W = 3
) (
	input  wire              pclk,
	input  wire              presetn,
	input  wire              psel,
	input  wire              penable,
	input  wire              pwrite,
	input  wire [ADDR_W-1:0] paddr,
	input  wire [31:0]       pwdata,
	output wire [31:0]       prdata,
	output wire              pready,
	output wire              pslverr,
	input  wire [RATE_W-1:0] watchdog_rate_select,
	input  wire              window_mode_bit,
	input  wire              wdog_in_window,
	input  wire              wdog_timeout,
	output wire              wdog_restart,
	output wire              wdog_reset_req,
	input  wire              high_temp_async,
	input  wire              analog_supply_low_async,
	output wire              voltage_source_select,
	output wire              temp_sensor_enable,
	output wire              bandgap_voltage_route,
	output wire              temperature_voltage_route,
	output wire              high_temp_irq,
	output wire              low_volt_irq
);

	// Bus decode
	wire        acc_phase;
	wire        wr_acc;
	wire        setup_phase;
	wire        hit_arm;
	wire        hit_temp;
	wire        hit_volt;
	wire        hit_any;
	wire [7:0]  wbyte;

	// Register state
	reg  [31:0] prdata_r;
	reg         src_sel_r;
	reg         sens_en_r;
	reg         ht_irq_en_r;
	reg         ht_flag_r;
	reg         ht_flag_nxt;
	reg         lv_irq_en_r;
	reg         lv_flag_r;
	reg         lv_flag_nxt;
	reg         armed_r;
	reg         restart_r;
	reg         reset_req_r;
	reg         bg_route_r;
	reg         ht_route_r;
	reg         ht_irq_r;
	reg         lv_irq_r;
	reg  [RATE_W-1:0] rate_prev_r;

	// Watchdog service decode
	wire        wdog_on;
	wire        arm_wr;
	wire        is_first;
	wire        is_second;
	wire        bad_value;
	wire        bad_time;
	wire        svc_done;
	wire        rate_started;

	// Monitor status
	wire        ht_status;
	wire        ht_chg;
	wire        lv_status;
	wire        lv_chg;

	// Read mux
	reg  [7:0]  rd_byte;

	assign setup_phase = psel & ~penable;
	assign acc_phase   = psel & penable;
	assign wr_acc      = acc_phase & pwrite;
	assign hit_arm     = (paddr == `PWR_ADDR_ARM);
	assign hit_temp    = (paddr == `PWR_ADDR_TEMP);
	assign hit_volt    = (paddr == `PWR_ADDR_VOLT);
	assign hit_any     = hit_arm | hit_temp | hit_volt;
	assign wbyte       = pwdata[7:0];

	// Zero wait states; unmapped addresses answer with an error
	assign pready  = 1'h1;
	assign pslverr = acc_phase & ~hit_any;
	assign prdata  = prdata_r;

	// Comparator inputs arrive from the analog domain
	pwr_sync_chg u_temp_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.async_in(high_temp_async),
		.level   (ht_status),
		.changed (ht_chg)
	);

	pwr_sync_chg u_volt_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.async_in(analog_supply_low_async),
		.level   (lv_status),
		.changed (lv_chg)
	);

	// Watchdog service sequence
	assign wdog_on   = (watchdog_rate_select != `PWR_RATE_OFF);
	assign arm_wr    = wr_acc & hit_arm & wdog_on;
	assign is_first  = (wbyte == `PWR_SVC_FIRST);
	assign is_second = (wbyte == `PWR_SVC_SECOND);
	assign bad_value = arm_wr & ~is_first & ~is_second;
	assign bad_time  = arm_wr & window_mode_bit & ~wdog_in_window;
	assign svc_done  = arm_wr & is_second & armed_r & ~bad_time;

	// Period starts when the rate leaves the disabled value
	assign rate_started = wdog_on & (rate_prev_r == `PWR_RATE_OFF);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			armed_r     <= `PWR_RST_BIT;
			restart_r   <= `PWR_RST_BIT;
			reset_req_r <= `PWR_RST_BIT;
			rate_prev_r <= `PWR_RST_RATE;
		end else begin
			rate_prev_r <= watchdog_rate_select;
			restart_r   <= svc_done | rate_started;
			// Single-cycle request to the reset controller
			reset_req_r <= bad_value | bad_time | (wdog_on & wdog_timeout);
			if (!wdog_on) begin
				armed_r <= 1'h0;
			end else if (arm_wr & is_first & ~bad_time) begin
				armed_r <= 1'h1;
			end else if (arm_wr) begin
				armed_r <= 1'h0;
			end
		end
	end

	assign wdog_restart   = restart_r;
	assign wdog_reset_req = reset_req_r;

	// Flags: a change in the clearing cycle wins over the clear
	always @* begin
		ht_flag_nxt = ht_flag_r;
		lv_flag_nxt = lv_flag_r;
		if (wr_acc & hit_temp & wbyte[`PWR_TC_FLAG]) begin
			ht_flag_nxt = 1'h0;
		end
		if (wr_acc & hit_volt & wbyte[`PWR_LV_FLAG]) begin
			lv_flag_nxt = 1'h0;
		end
		if (ht_chg) begin
			ht_flag_nxt = 1'h1;
		end
		if (lv_chg) begin
			lv_flag_nxt = 1'h1;
		end
	end

	// Control registers
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_sel_r   <= `PWR_RST_BIT;
			sens_en_r   <= `PWR_RST_BIT;
			ht_irq_en_r <= `PWR_RST_BIT;
			ht_flag_r   <= `PWR_RST_BIT;
			lv_irq_en_r <= `PWR_RST_BIT;
			lv_flag_r   <= `PWR_RST_BIT;
		end else begin
			ht_flag_r <= ht_flag_nxt;
			lv_flag_r <= lv_flag_nxt;
			if (wr_acc & hit_temp) begin
				src_sel_r   <= wbyte[`PWR_TC_SRC_SEL];
				sens_en_r   <= wbyte[`PWR_TC_SENS_EN];
				ht_irq_en_r <= wbyte[`PWR_TC_IRQ_EN];
			end
			if (wr_acc & hit_volt) begin
				lv_irq_en_r <= wbyte[`PWR_LV_IRQ_EN];
			end
		end
	end

	// Analog routing and interrupt outputs
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bg_route_r <= `PWR_RST_BIT;
			ht_route_r <= `PWR_RST_BIT;
			ht_irq_r   <= `PWR_RST_BIT;
			lv_irq_r   <= `PWR_RST_BIT;
		end else begin
			bg_route_r <= sens_en_r & src_sel_r;
			ht_route_r <= sens_en_r & ~src_sel_r;
			ht_irq_r   <= ht_flag_nxt & ht_irq_en_r;
			lv_irq_r   <= lv_flag_nxt & lv_irq_en_r;
		end
	end

	assign voltage_source_select     = src_sel_r;
	assign temp_sensor_enable        = sens_en_r;
	assign bandgap_voltage_route     = bg_route_r;
	assign temperature_voltage_route = ht_route_r;
	assign high_temp_irq             = ht_irq_r;
	assign low_volt_irq              = lv_irq_r;

	// Read data
	always @* begin
		rd_byte = `PWR_RST_BYTE;
		if (hit_arm) begin
			rd_byte = `PWR_ARM_READ;
		end else if (hit_temp) begin
			rd_byte[`PWR_TC_SRC_SEL] = src_sel_r;
			rd_byte[`PWR_TC_SENS_EN] = sens_en_r;
			rd_byte[`PWR_TC_STATUS]  = ht_status;
			rd_byte[`PWR_TC_IRQ_EN]  = ht_irq_en_r;
			rd_byte[`PWR_TC_FLAG]    = ht_flag_r;
		end else if (hit_volt) begin
			rd_byte[`PWR_LV_STATUS] = lv_status;
			rd_byte[`PWR_LV_IRQ_EN] = lv_irq_en_r;
			rd_byte[`PWR_LV_FLAG]   = lv_flag_r;
		end
	end

	// Read data is captured in the setup cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= `PWR_RST_WORD;
		end else if (setup_phase) begin
			prdata_r <= {24'h000000, rd_byte};
		end
	end

endmodule // pwr_regs

`default_nettype wire

// file: pwr_defs.vh
// Address map, field positions and constants of the watchdog and monitor register slice
`ifndef PWR_DEFS_VH
`define PWR_DEFS_VH

// Register indices; byte address is four times the index
`define PWR_IDX_ARM        10'h00F
`define PWR_IDX_TEMP       10'h010
`define PWR_IDX_VOLT       10'h011
`define PWR_ADDR_ARM       12'h03C
`define PWR_ADDR_TEMP      12'h040
`define PWR_ADDR_VOLT      12'h044

// Service sequence bytes and service register read value
`define PWR_SVC_FIRST      8'h55
`define PWR_SVC_SECOND     8'hAA
`define PWR_ARM_READ       8'h00

// Watchdog rate select value meaning disabled
`define PWR_RATE_OFF       3'h0

// Temperature control fields
`define PWR_TC_SRC_SEL     5
`define PWR_TC_SENS_EN     3
`define PWR_TC_STATUS      2
`define PWR_TC_IRQ_EN      1
`define PWR_TC_FLAG        0

// Low-voltage control fields
`define PWR_LV_STATUS      2
`define PWR_LV_IRQ_EN      1
`define PWR_LV_FLAG        0

// Reset values
`define PWR_RST_BIT        1'h0
`define PWR_RST_BYTE       8'h00
`define PWR_RST_WORD       32'h0000_0000
`define PWR_RST_RATE       3'h0

`endif

// file: pwr_sync_chg.v
// Two-stage synchroniser with level change detection
`timescale 1ns/10ps
`default_nettype none
`include "pwr_defs.vh"

module pwr_sync_chg (
	input  wire pclk,
	input  wire presetn,
	input  wire async_in,
	output wire level,
	output wire changed
);

	reg sync1_r;
	reg sync2_r;
	reg level_r;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_r <= `PWR_RST_BIT;
			sync2_r <= `PWR_RST_BIT;
			level_r <= `PWR_RST_BIT;
		end else begin
			sync1_r <= async_in;
			sync2_r <= sync1_r;
			level_r <= sync2_r;
		end
	end

	// One pulse per settled level change
	assign level   = level_r;
	assign changed = sync2_r ^ level_r;

endmodule // pwr_sync_chg

`default_nettype wire

// file: pwr_regs_props.sv
// Checker of watchdog service register behaviour and of the bandgap and temperature route outputs
`timescale 1ns/10ps
`default_nettype none
`include "pwr_defs.vh"
module pwr_regs_props (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic [2:0]  watchdog_rate_select,
	input wire logic        window_mode_bit,
	input wire logic        wdog_in_window,
	input wire logic        wdog_timeout,
	input wire logic        wdog_restart,
	input wire logic        wdog_reset_req,
	input wire logic        voltage_source_select,
	input wire logic        temp_sensor_enable,
	input wire logic        bandgap_voltage_route,
	input wire logic        temperature_voltage_route
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire       acc = psel && penable;
	wire       hit = acc && pwrite && paddr == `PWR_ADDR_ARM;
	wire       arm = hit && watchdog_rate_select != `PWR_RATE_OFF;
	wire [7:0] b   = pwdata[7:0];
	sequence s_first;
		arm && b == `PWR_SVC_FIRST && !wdog_timeout && (!window_mode_bit || wdog_in_window);
	endsequence
	chk_arm_reads_zero: assert property (
		acc && !pwrite && paddr == `PWR_ADDR_ARM |-> prdata == `PWR_RST_WORD)
		else $error("service register read not zero");
	chk_off_ignored: assert property (
		hit && watchdog_rate_select == `PWR_RATE_OFF |=> !wdog_reset_req && !wdog_restart)
		else $error("service write acted while disabled");
	chk_bad_byte: assert property (
		arm && b != `PWR_SVC_FIRST && b != `PWR_SVC_SECOND |=> wdog_reset_req)
		else $error("illegal byte gave no reset");
	chk_restart_cause: assert property (
		wdog_restart |-> $past(arm && b == `PWR_SVC_SECOND) || !$past(presetn, 2)
			|| $past(watchdog_rate_select, 2) == `PWR_RATE_OFF)
		else $error("restart without cause");
	chk_first_safe: assert property (s_first |=> !wdog_reset_req)
		else $error("first byte caused reset");
	chk_window_early: assert property (
		arm && window_mode_bit && !wdog_in_window |=> wdog_reset_req && !wdog_restart)
		else $error("early window write not reset");
	chk_timeout_reset: assert property (
		wdog_timeout && watchdog_rate_select != `PWR_RATE_OFF |=> wdog_reset_req)
		else $error("timeout gave no reset");
	chk_reset_pulse: assert property (wdog_reset_req |=> !wdog_reset_req)
		else $error("reset request longer than one cycle");
	chk_route_bandgap: assert property (
		bandgap_voltage_route == $past(temp_sensor_enable && voltage_source_select))
		else $error("bandgap route does not follow enable and select");
	chk_route_tempv: assert property (
		temperature_voltage_route == $past(temp_sensor_enable && !voltage_source_select))
		else $error("temperature route does not follow enable and select");
endmodule // pwr_regs_props
bind pwr_regs pwr_regs_props u_props (.*);
`default_nettype wire

// file: pmu_watchdog_arm_and_monitor_regs_tb_top.sv
// Self-checking bench of the watchdog and monitor registers
`timescale 1ns/10ps
`default_nettype none
`include "pwr_defs.vh"
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module pmu_watchdog_arm_and_monitor_regs_tb_top;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, rd;
	logic [2:0]  rate = 3'h0;
	logic        wmode = 0, inwin = 0, tout = 0, slv;
	logic [1:0]  cmp = 2'h0;
	wire  [31:0] prdata;
	wire         pready, pslverr, rsq, rrq, vss, tse, bgr, tvr, hti, lvi;
	int          fail_count = 0, n_compared = 0, n_rs = 0, n_rr = 0;
	pwr_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .watchdog_rate_select(rate), .window_mode_bit(wmode),
		.wdog_in_window(inwin), .wdog_timeout(tout), .wdog_restart(rsq), .wdog_reset_req(rrq),
		.high_temp_async(cmp[0]), .analog_supply_low_async(cmp[1]), .voltage_source_select(vss),
		.temp_sensor_enable(tse), .bandgap_voltage_route(bgr), .temperature_voltage_route(tvr),
		.high_temp_irq(hti), .low_volt_irq(lvi));
	always #20 pclk = ~pclk;
	// Pulses counted mid-cycle; an unknown counts as a pulse
	always @(negedge pclk) begin
		n_rs += (rsq !== 1'h0);
		n_rr += (rrq !== 1'h0);
	end
	function logic [31:0] f_ctl(input logic [7:0] w, m, s);
		return {24'h0, (w & m) | s};
	endfunction
	task apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
		psel <= 1; pwrite <= wr; paddr <= a; pwdata <= {24'h0, d};
		@(posedge pclk) penable <= 1;
		@(posedge pclk);
		// Request held through wait states; only the watchdog ends a hang
		while (pready !== 1'h1) @(posedge pclk);
		rd = prdata; slv = pslverr;
		psel <= 0; penable <= 0;
		@(posedge pclk);
	endtask
	task summarize();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		logic [11:0] a;
		logic [7:0] w, m, b;
		void'($urandom(30));
		repeat (4) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		apb(0, 12'h048, 8'h0); `CHK("unmapped err", 1'h1, slv)
		apb(0, `PWR_ADDR_VOLT, 8'h0); `CHK("volt rst", 32'h0, rd)
		`CHK("mapped err", 1'h0, slv)
		apb(1, `PWR_ADDR_ARM, 8'h12); apb(0, `PWR_ADDR_ARM, 8'h0);
		`CHK("arm read", 32'h0, rd)
		`CHK("off resets", 0, n_rr + n_rs)
		rate <= 3'($urandom_range(7, 1));
		repeat (3) @(posedge pclk);
		`CHK("rate start", 1, n_rs)
		apb(1, `PWR_ADDR_ARM, 8'h55); apb(1, `PWR_ADDR_ARM, 8'h55);
		apb(0, `PWR_ADDR_ARM, 8'h0); `CHK("armed read", 32'h0, rd)
		apb(0, `PWR_ADDR_TEMP, 8'h0); apb(1, `PWR_ADDR_ARM, 8'hAA);
		`CHK("pair restart", 2, n_rs)
		`CHK("pair no reset", 0, n_rr)
		apb(1, `PWR_ADDR_ARM, 8'hAA);
		`CHK("lone second", 2, n_rs + n_rr)
		for (int i = 1; i < 5; i++) begin
			b = 8'($urandom);
			if (b == 8'h55 || b == 8'hAA) b = 8'h13;
			apb(1, `PWR_ADDR_ARM, b); `CHK("bad byte", i, n_rr)
		end
		wmode <= 1;
		apb(1, `PWR_ADDR_ARM, 8'h55); `CHK("early window", 5, n_rr)
		inwin <= 1;
		apb(1, `PWR_ADDR_ARM, 8'h55); apb(1, `PWR_ADDR_ARM, 8'hAA);
		`CHK("window pair", 3, n_rs)
		tout <= 1;
		@(posedge pclk) tout <= 0;
		@(posedge pclk);
		`CHK("timeout", 6, n_rr)
		$display("watchdog test done");
		for (int i = 0; i < 2; i++) begin
			a = i ? `PWR_ADDR_VOLT : `PWR_ADDR_TEMP;
			m = i ? 8'h02 : 8'h2A;
			w = 8'($urandom) | 8'h02;
			apb(1, a, w); apb(0, a, 8'h0);
			`CHK("ctl", f_ctl(w, m, 8'h0), rd)
			if (i == 0) `CHK("src sel", w[5], vss)
			if (i == 0) `CHK("sens en", w[3], tse)
			if (i == 0) `CHK("bandgap", w[3] & w[5], bgr)
			if (i == 0) `CHK("tempv", w[3] & ~w[5], tvr)
			cmp[i] <= 1;
			repeat (5) @(posedge pclk);
			apb(0, a, 8'h0); `CHK("status", f_ctl(w, m, 8'h05), rd)
			`CHK("irq on", 1'h1, i ? lvi : hti)
			apb(1, a, w & 8'hFA); apb(0, a, 8'h0);
			`CHK("wr0", f_ctl(w, m, 8'h05), rd)
			apb(1, a, w & 8'hFD | 8'h01); apb(0, a, 8'h0);
			`CHK("clear", f_ctl(w & 8'hFD, m, 8'h04), rd)
			cmp[i] <= 0;
			repeat (5) @(posedge pclk);
			apb(0, a, 8'h0); `CHK("fall", f_ctl(w & 8'hFD, m, 8'h01), rd)
			`CHK("irq off", 1'h0, i ? lvi : hti)
		end
		$display("monitor test done");
		summarize();
	end
	// About 130 cycles expected; ten thousand means a hang
	initial begin
		#400000;
		fail_count++;
		summarize();
	end
endmodule // pmu_watchdog_arm_and_monitor_regs_tb_top
`default_nettype wire
